// *** rtl/flag_sync.v ***
`default_nettype none
module flag_sync #(
   parameter W = 4
) (
   input  wire         sys_clk,
   input  wire         rst_n,
   input  wire         clk_en,
   input  wire [W-1:0] d_in,
   output wire [W-1:0] d_out
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         always @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
            end
            else if (clk_en)
            begin
               meta_q[i] <= d_in[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate
   assign d_out = sync_q;
endmodule // flag_sync
`default_nettype wire

// *** rtl/kick_watchdog.v ***
`default_nettype none
`include "supervisor_consts.vh"
module kick_watchdog #(
   parameter [31:0] SHORT_CYC = `WDOG_SHORT_CYC,
   parameter [31:0] LONG_CYC  = `WDOG_LONG_CYC,
   parameter [31:0] PULSE_CYC = `WDOG_PULSE_CYC
) (
   input  wire sys_clk,
   input  wire rst_n,
   input  wire clk_en,
   input  wire hold,
   input  wire enable,
   input  wire use_internal,
   input  wire long_sel,
   input  wire cap_tick,
   input  wire kick,
   output reg  timeout_pulse
);
   reg  [31:0] cnt_q;
   reg  [31:0] pcnt_q;
   reg         kick_q;
   wire        toggled = kick ^ kick_q;
   wire [31:0] limit   = long_sel ? LONG_CYC : SHORT_CYC;
   wire        adv     = use_internal | cap_tick;
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q         <= 32'h0;
         pcnt_q        <= 32'h0;
         kick_q        <= 1'b0;
         timeout_pulse <= 1'b0;
      end
      else if (clk_en)
      begin
         kick_q <= kick;
         if (pcnt_q != 32'h0)
         begin
            pcnt_q        <= pcnt_q - 32'h1;
            timeout_pulse <= (pcnt_q != 32'h1);
         end
         else
            timeout_pulse <= 1'b0;
         if (hold || !enable)
            cnt_q <= 32'h0;
         // [RL16] Both edges restart.
         else if (toggled)
            cnt_q <= 32'h0;
         // [RL1] Timebase source choice.
         else if (adv)
         begin
            // [RL2] Period limit reached.
            // [RL7] Timeout pulse issued.
            if (cnt_q >= limit - 32'h1)
            begin
               cnt_q         <= 32'h0;
               pcnt_q        <= PULSE_CYC;
               timeout_pulse <= 1'b1;
            end
            else
               cnt_q <= cnt_q + 32'h1;
         end
      end
   end
endmodule // kick_watchdog
`default_nettype wire

// *** rtl/supervisor_consts.vh ***
`ifndef SUPERVISOR_CONSTS_VH
`define SUPERVISOR_CONSTS_VH
`define CLK_HZ          200000000
`define RESET_HOLD_MS   50
`define WDOG_SHORT_MS   100
`define WDOG_LONG_MS    1600
`define RESET_HOLD_CYC  (`CLK_HZ / 1000 * `RESET_HOLD_MS)
`define WDOG_SHORT_CYC  (`CLK_HZ / 1000 * `WDOG_SHORT_MS)
`define WDOG_LONG_CYC   (`CLK_HZ / 1000 * `WDOG_LONG_MS)
`define WDOG_PULSE_CYC  16
`define CNT_W           32
`endif

// *** rtl/supply_supervisor_watchdog.v ***
// How it works
// [RL1] Select low uses capacitor timebase; high uses internal oscillator.
// [RL2] Internal oscillator offers 100 ms or 1.6 s, chosen statically.
// [RL3] Backup cell within 50 mV of main supply gives a reset pulse.
// [RL4] Reset is low while low-line sense is below threshold.
// [RL5] Reset stays low 50 ms after low-line sense recovers.
// [RL6] Processor must toggle kick within every selected period (100 ms or 1.6 s).
// [RL7] Missing kick within period gives a reset pulse.
// [RL8] Floating kick input disables the watchdog.
// [RL9] Early-warning flag asserts while early-warning sense is low.
// [RL10] Early-warning threshold should sit above reset threshold.
// [RL11] Backup indicator low while main exceeds cell, high otherwise.
// [RL12] Switched supply uses main normally, backup cell on failure.
// [RL13] Gated chip-select follows input above threshold, high below.
// [RL14] Backup mode ignores kick, select; holds select high, reset, flag low.
// [RL15] Comparator flags are synchronised before use.
// [RL16] Either kick edge restarts the watchdog count.
`default_nettype none
`include "supervisor_consts.vh"
module supply_supervisor_watchdog #(
   parameter [31:0] HOLD_CYC  = `RESET_HOLD_CYC,
   parameter [31:0] SHORT_CYC = `WDOG_SHORT_CYC,
   parameter [31:0] LONG_CYC  = `WDOG_LONG_CYC,
   parameter [31:0] PULSE_CYC = `WDOG_PULSE_CYC
) (
   input  wire sys_clk,
   input  wire rst_n,
   input  wire clk_en,
   input  wire period_source_select,
   input  wire timing_cap_input,
   input  wire period_long_sel,
   input  wire watchdog_kick_in,
   input  wire watchdog_kick_driven,
   input  wire low_line_sense,
   input  wire early_warning_sense,
   input  wire main_above_cell,
   input  wire cell_near_main,
   input  wire chip_select_in,
   output reg  reset_out_n,
   output reg  early_warning_flag,
   output reg  backup_switch_indicator,
   output reg  switched_supply,
   output reg  chip_select_gated
);
   wire [3:0] raw_flags;
   wire [3:0] s_flags;
   wire       line_ok;
   wire       warn_ok;
   wire       main_up;
   wire       near;
   wire       backup;
   wire       wd_pulse;
   reg        near_q;
   reg        cap_q;
   reg [31:0] hold_q;
   reg        hold_busy_q;
   reg [31:0] npcnt_q;

   assign raw_flags = {cell_near_main, main_above_cell,
                       early_warning_sense, low_line_sense};

   // [RL15] Comparator flag sync.
   flag_sync #(
      .W (4)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .d_in    (raw_flags),
      .d_out   (s_flags)
   );

   assign line_ok = s_flags[0];
   assign warn_ok = s_flags[1];
   assign main_up = s_flags[2];
   assign near    = s_flags[3];
   assign backup  = ~main_up;

   kick_watchdog #(
      .SHORT_CYC (SHORT_CYC),
      .LONG_CYC  (LONG_CYC),
      .PULSE_CYC (PULSE_CYC)
   ) u_wdog (
      .sys_clk       (sys_clk),
      .rst_n         (rst_n),
      .clk_en        (clk_en),
      // [RL14] Kick ignored in backup.
      .hold          (backup | ~reset_out_n),
      // [RL8] Floating kick disables.
      .enable        (watchdog_kick_driven),
      .use_internal  (period_source_select),
      .long_sel      (period_long_sel),
      .cap_tick      (timing_cap_input & ~cap_q),
      .kick          (watchdog_kick_in),
      .timeout_pulse (wd_pulse)
   );

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         near_q                  <= 1'b0;
         cap_q                   <= 1'b0;
         hold_q                  <= 32'h0;
         hold_busy_q             <= 1'b1;
         npcnt_q                 <= 32'h0;
         reset_out_n             <= 1'b0;
         early_warning_flag      <= 1'b0;
         backup_switch_indicator <= 1'b1;
         switched_supply         <= 1'b1;
         chip_select_gated       <= 1'b1;
      end
      else if (clk_en)
      begin
         near_q <= near;
         cap_q  <= timing_cap_input;
         // [RL3] Near-cell reset pulse.
         if (near && !near_q)
            npcnt_q <= PULSE_CYC - 32'h1;
         else if (npcnt_q != 32'h0)
            npcnt_q <= npcnt_q - 32'h1;
         // [RL4] Low line holds reset.
         if (!line_ok || backup)
         begin
            hold_q      <= 32'h0;
            hold_busy_q <= 1'b1;
         end
         // [RL5] Release delay count.
         else if (hold_busy_q)
         begin
            if (hold_q >= HOLD_CYC - 32'h1)
               hold_busy_q <= 1'b0;
            else
               hold_q <= hold_q + 32'h1;
         end
         // [RL7] Watchdog pulse drives reset.
         reset_out_n <= ~(hold_busy_q | !line_ok | backup | wd_pulse
                          | (npcnt_q != 32'h0) | (near && !near_q));
         // [RL9] Early-warning flag.
         early_warning_flag <= ~backup & ~warn_ok;
         // [RL11] Backup indicator.
         backup_switch_indicator <= ~main_up;
         // [RL12] Supply source choice.
         switched_supply <= main_up;
         // [RL13] Chip-select gating.
         chip_select_gated <= (!line_ok || backup) ? 1'b1 : chip_select_in;
      end
   end
endmodule // supply_supervisor_watchdog
`default_nettype wire

// *** testbench/kick_source.sv ***
`default_nettype none
module kick_source (
   input  wire logic sys_clk,
   input  wire logic run,
   output var  logic kick
);
   timeunit 1ns;
   timeprecision 100ps;
   initial kick = 1'b0;
   always @(negedge sys_clk) if (run) kick <= ~kick;
endmodule // kick_source
`default_nettype wire

// *** testbench/supervisor_properties.sv ***
`default_nettype none
module supervisor_properties #(
   parameter [31:0] HOLD_CYC  = 20,
   parameter [31:0] SHORT_CYC = 30,
   parameter [31:0] LONG_CYC  = 60
) (
   input wire sys_clk, rst_n, low_line_sense, early_warning_sense,
   input wire main_above_cell, cell_near_main, chip_select_in,
   input wire watchdog_kick_in, watchdog_kick_driven, period_long_sel,
   input wire reset_out_n, early_warning_flag, backup_switch_indicator,
   input wire switched_supply, chip_select_gated
);
   reg  [31:0] ll_q, idle_q;
   reg         kick_q;
   wire [31:0] lim = period_long_sel ? LONG_CYC : SHORT_CYC;
   wire        up = ll_q > HOLD_CYC + 8;
   always @(posedge sys_clk or negedge rst_n)
   begin
      ll_q <= !rst_n ? 0 : (low_line_sense ? ll_q + 1 : 0);
      kick_q <= rst_n & watchdog_kick_in;
      idle_q <= (!rst_n || !reset_out_n || kick_q != watchdog_kick_in)
                ? 0 : idle_q + 1;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   low_reset_a: assert property ($fell(low_line_sense) |->
      ##[1:4] !reset_out_n) else $error("reset not asserted");
   cs_force_a: assert property (!low_line_sense [*4] |->
      chip_select_gated) else $error("select not forced high");
   cs_follow_a: assert property ((low_line_sense && main_above_cell) [*5]
      |-> chip_select_gated == $past(chip_select_in, 1))
      else $error("select not following");
   warn_flag_a: assert property ((!early_warning_sense &&
      main_above_cell) [*4] |-> early_warning_flag) else $error("no warning");
   backup_hold_a: assert property (!main_above_cell [*4] |->
      !reset_out_n && !early_warning_flag && chip_select_gated &&
      backup_switch_indicator && !switched_supply) else $error("backup state");
   main_state_a: assert property (main_above_cell [*4] |->
      !backup_switch_indicator && switched_supply) else $error("main state");
   hold_time_a: assert property ($rose(reset_out_n) |->
      ll_q >= HOLD_CYC) else $error("reset released early");
   pulse_len_a: assert property ($fell(reset_out_n) && up && main_above_cell
      |-> !reset_out_n [*4] ##1 reset_out_n) else $error("pulse length");
   near_reset_a: assert property ($rose(cell_near_main) && up |->
      ##[2:5] !reset_out_n) else $error("no near-cell reset");
   wd_early_a: assert property ($fell(reset_out_n) && up && !cell_near_main
      && watchdog_kick_driven && main_above_cell |-> idle_q + 4 >= lim)
      else $error("early bite");
   cover property ($fell(reset_out_n) && up);
   cover property (!main_above_cell [*4]);
   cover property ($rose(reset_out_n));
endmodule // supervisor_properties
bind supply_supervisor_watchdog supervisor_properties #(.HOLD_CYC(HOLD_CYC),
   .SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) props_inst (.sys_clk(sys_clk),
   .rst_n(rst_n), .low_line_sense(low_line_sense),
   .early_warning_sense(early_warning_sense), .main_above_cell(main_above_cell),
   .cell_near_main(cell_near_main), .chip_select_in(chip_select_in),
   .watchdog_kick_in(watchdog_kick_in), .period_long_sel(period_long_sel),
   .watchdog_kick_driven(watchdog_kick_driven), .reset_out_n(reset_out_n),
   .early_warning_flag(early_warning_flag), .switched_supply(switched_supply),
   .backup_switch_indicator(backup_switch_indicator),
   .chip_select_gated(chip_select_gated));
`default_nettype wire

// *** testbench/supply_supervisor_watchdog_tb_top.sv ***
`default_nettype none
module supply_supervisor_watchdog_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam integer HOLD = 20, SHORT = 30, LONG = 60;
   logic sys_clk, rst_n, src, lsel, run, drv, ll, ew, main_ok, near;
   logic cap = 1'b0, cs = 1'b1;
   wire  kick, rst_o_n, flag, ind, sup, cs_g;
   integer seed = 68, miscompares = 0, comparisons = 0, cycles = 0, n, i;
   supply_supervisor_watchdog #(.HOLD_CYC(HOLD), .SHORT_CYC(SHORT),
      .LONG_CYC(LONG), .PULSE_CYC(4)) supply_supervisor_watchdog_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
      .period_source_select(src), .timing_cap_input(cap),
      .period_long_sel(lsel), .watchdog_kick_in(kick),
      .watchdog_kick_driven(drv), .low_line_sense(ll),
      .early_warning_sense(ew), .main_above_cell(main_ok),
      .cell_near_main(near), .chip_select_in(cs), .reset_out_n(rst_o_n),
      .early_warning_flag(flag), .backup_switch_indicator(ind),
      .switched_supply(sup), .chip_select_gated(cs_g));
   kick_source kick_source_inst (.sys_clk(sys_clk), .run(run), .kick(kick));
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   function integer exp_lim(input integer m);
      exp_lim = m == 1 ? LONG : (m == 2 ? 2 * SHORT : SHORT);
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp,
              input string name);
      comparisons++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
         miscompares++;
      end
   endtask
   task wait_rst(input logic lvl, input integer lim, output integer m);
      m = 0;
      while (rst_o_n !== lvl && m < lim)
      begin
         @(negedge sys_clk);
         m++;
      end
   endtask
   task stop_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(negedge sys_clk)
   begin
      cap <= ~cap;
      cs <= ($random(seed) % 2) != 0;
   end
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         miscompares++;
         stop_test;
      end
   end
   initial
   begin
      {rst_n, src, lsel, run, drv, ll, ew, main_ok, near} = 9'h0fe;
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk) rst_n = 1'b1;
      wait_rst(1'b1, 200, n);
      check(n >= HOLD && n <= HOLD + 6, 1, "hold");
      // Warning drops ahead of low line.
      ew = 1'b0;
      #50 check(flag, 1, "warn");
      ll = 1'b0;
      #50 check({rst_o_n, cs_g}, 2'b01, "lowline");
      {ll, ew} = 2'b11;
      wait_rst(1'b1, 200, n);
      check(n >= HOLD && n <= HOLD + 6, 1, "rehold");
      // Internal short, internal long, then capacitor short period in turn.
      for (i = 0; i < 3; i++)
      begin
         {src, lsel} = {i < 2, i == 1};
         #50 run = 1'b0;
         wait_rst(1'b0, 400, n);
         check(n + 2 >= exp_lim(i) && n <= exp_lim(i) + 8, 1, "bite");
         wait_rst(1'b1, 20, n);
         run = 1'b1;
      end
      {drv, run, n} = 0;
      repeat (2 * LONG) @(negedge sys_clk) n += !rst_o_n;
      check(n, 0, "floating");
      {drv, run, near} = 3'h7;
      wait_rst(1'b0, 10, n);
      check(n <= 6, 1, "near");
      #50 near = 1'b0;
      #50 main_ok = 1'b0;
      #30 check({ind, sup, cs_g, rst_o_n, flag}, 5'h14, "backup");
      stop_test;
   end
endmodule // supply_supervisor_watchdog_tb_top
`default_nettype wire
